/* File: src/isa_pnp_defs.svh */
`ifndef ISA_PNP_DEFS_SVH
`define ISA_PNP_DEFS_SVH

// Configuration register indexes
`define IDX_RDPORT 8'h00
`define IDX_LDN 8'h07
`define IDX_ACTIVATE 8'h30
`define IDX_CHECK 8'h31
`define IDX_BASE_HI 8'h60
`define IDX_BASE_LO 8'h61
`define IDX_IRQ_SEL 8'h70
`define IDX_IRQ_TYPE 8'h71
`define IDX_AUTO 8'hf0
`define IDX_SAMPLE 8'hf1
`define IDX_LEVELS 8'hf2

// Constant read values
`define LDN_VALUE 8'h00
`define IRQ_TYPE_VALUE 8'h02
`define CHECK_ANS_ONE 8'h55
`define CHECK_ANS_ZERO 8'haa

// Field positions
`define ACTIVATE_BIT 0
`define CHECK_EN_BIT 1
`define CHECK_PAT_BIT 0
`define SAMPLE_BIT 0
`define PULL_BIT 1

// Fixed host ports, reset values, last key position and I/O window length
`define ADDR_PORT 16'h0279
`define WDATA_PORT 16'h0a79
`define RDPORT_RST 8'h80
`define INDEX_RST 8'h00
`define AUTO_RST 8'h00
`define KEY_LAST 5'h1f
`define IO_RANGE_LEN 16'h0008

`endif

/* File: src/isa_pnp_pkg.sv */
package isa_pnp_pkg;

  // Which unlock key opened the configuration ports
  typedef enum logic {
    MODE_VENDOR,
    MODE_STANDARD
  } cfg_mode_e;

  // One sample of the host bus pins
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic ior_n;
    logic iow_n;
  } isa_bus_s;

  // Logical device configuration values
  typedef struct packed {
    logic [7:0] base_hi;
    logic [4:0] base_lo;
    logic [3:0] irq_sel;
  } dev_cfg_s;

  // Standard unlock key, compared byte by byte
  localparam logic [7:0] STD_KEY [0:31] = '{
    8'h6a, 8'hb5, 8'hda, 8'hed, 8'hf6, 8'hfb, 8'h7d, 8'hbe,
    8'hdf, 8'h6f, 8'h37, 8'h1b, 8'h0d, 8'h86, 8'hc3, 8'h61,
    8'hb0, 8'h58, 8'h2c, 8'h16, 8'h8b, 8'h45, 8'ha2, 8'hd1,
    8'he8, 8'h74, 8'h3a, 8'h9d, 8'hce, 8'he7, 8'h73, 8'h39};

  // Vendor unlock key, compared byte by byte
  localparam logic [7:0] VEN_KEY [0:31] = '{
    8'h68, 8'h34, 8'h1a, 8'h8d, 8'hcb, 8'he3, 8'h71, 8'hb8,
    8'h5c, 8'h2e, 8'h97, 8'h4b, 8'h25, 8'h92, 8'hc9, 8'he4,
    8'h72, 8'hb9, 8'hdc, 8'h6e, 8'hb7, 8'h5b, 8'h2d, 8'h96,
    8'hcb, 8'h65, 8'hb2, 8'hd9, 8'hec, 8'h76, 8'hbb, 8'h5d};

endpackage : isa_pnp_pkg

/* File: src/isa_pnp_config_logic.sv */
`timescale 1ns/1ps
`default_nettype none
`include "isa_pnp_defs.svh"

module isa_pnp_config_logic (
  input wire logic core_clk, // System clock, 250 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic [15:0] isa_addr, // Host I/O address pins
  input wire logic [7:0] isa_din, // Host data bus, input side
  input wire logic isa_ior_n, // Host I/O read strobe
  input wire logic isa_iow_n, // Host I/O write strobe
  input wire logic [15:0] irq_pins, // Host interrupt line levels
  input wire isa_pnp_pkg::dev_cfg_s dflt_cfg, // Stored defaults from MCU
  input wire logic mcu_auto_wr, // MCU writes auto setup
  input wire logic [7:0] mcu_auto_data, // MCU auto setup value
  output logic [7:0] isa_dout, // Host data bus, output side
  output logic isa_doe_n, // Data bus enable, low drives
  output logic dev_active, // Logical device active
  output isa_pnp_pkg::dev_cfg_s dev_cfg, // Current configuration
  output logic irq_sel_valid, // IRQ selection non-zero, low until the first clock after reset
  output logic pull_low_en, // IRQ pull-low resistors on
  output logic [7:0] auto_setup, // Auto setup register
  output logic auto_req, // Pulse: host wrote auto setup
  output logic cfg_enabled, // Config data ports open
  output isa_pnp_pkg::cfg_mode_e cfg_mode, // Mode chosen by key
  output logic cfg_from_auto // Source is auto setup
);
  import isa_pnp_pkg::*;

  // Pin synchronisers; stage one feeds stage two only
  isa_bus_s bus_s1_r, bus_s2_r, bus_s3_r;
  logic [15:0] irq_s1_r, irq_s2_r;

  // Configuration state
  logic [7:0] index_r, index_nxt; // Selected register index
  logic [7:0] rdport_r, rdport_nxt; // Read port address bits 9..2
  logic active_r, active_nxt; // Device active
  logic [1:0] check_r, check_nxt; // Range check enable and pattern
  dev_cfg_s cfg_r, cfg_nxt; // Base and IRQ selection
  logic [7:0] auto_r, auto_nxt; // Auto setup value
  logic auto_req_r, auto_req_nxt; // EEPROM update request
  logic pull_r, pull_nxt; // Pull-low enable
  logic [7:0] levels_r, levels_nxt; // Latched IRQ levels
  logic en_r, en_nxt; // Data ports unlocked
  cfg_mode_e mode_r, mode_nxt; // Unlock mode
  logic src_auto_r, src_auto_nxt; // Configuration source
  logic [4:0] std_pos_r, std_pos_nxt; // Standard key progress
  logic [4:0] ven_pos_r, ven_pos_nxt; // Vendor key progress
  logic [7:0] dout_r, dout_nxt; // Read answer
  logic doe_n_r, doe_n_nxt; // Read answer enable, low drives
  logic irq_ok_r, irq_ok_nxt; // Non-zero IRQ selection

  // Decoded bus events
  logic wr_evt, rd_evt, rdport_hit, chk_hit;
  logic [15:0] rd_port_addr;

  // Base address of the device's I/O window
  function automatic logic [15:0] base_of(input dev_cfg_s c);
    base_of = {c.base_hi, c.base_lo, 3'h0};
  endfunction : base_of

  // Window hit test; wrap past the top of I/O space is not decoded
  function automatic logic in_window(input logic [15:0] a, input logic [15:0] b);
    in_window = (a >= b) && ({1'b0, a} < ({1'b0, b} + {1'b0, `IO_RANGE_LEN}));
  endfunction : in_window

  // Next key position: a mismatch restarts, but may itself start a new key
  function automatic logic [4:0] key_step(input logic [7:0] d, input logic [7:0] exp,
                                          input logic [7:0] first, input logic [4:0] pos);
    if (d == exp) begin
      key_step = pos + 5'h01;
    end else if (d == first) begin
      key_step = 5'h01;
    end else begin
      key_step = 5'h00;
    end
  endfunction : key_step

  // Read data of the selected register; unknown indexes give zero
  function automatic logic [7:0] read_mux(input logic [7:0] idx);
    case (idx)
      `IDX_LDN: read_mux = `LDN_VALUE;
      `IDX_ACTIVATE: read_mux = {7'h00, active_r};
      `IDX_CHECK: read_mux = {6'h00, check_r};
      `IDX_BASE_HI: read_mux = cfg_r.base_hi;
      `IDX_BASE_LO: read_mux = {cfg_r.base_lo, 3'h0};
      `IDX_IRQ_SEL: read_mux = {4'h0, cfg_r.irq_sel};
      `IDX_IRQ_TYPE: read_mux = `IRQ_TYPE_VALUE;
      `IDX_AUTO: read_mux = auto_r;
      `IDX_LEVELS: read_mux = levels_r;
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // Two flops on every pin, third stage only for strobe edges
  always_ff @(posedge core_clk) begin
    bus_s1_r <= {isa_addr, isa_din, isa_ior_n, isa_iow_n};
    bus_s2_r <= bus_s1_r;
    bus_s3_r <= bus_s2_r;
    irq_s1_r <= irq_pins;
    irq_s2_r <= irq_s1_r;
  end

  // Strobe edges seen as ordinary bus cycles, one event per cycle
  always_comb begin
    wr_evt = bus_s3_r.iow_n && !bus_s2_r.iow_n;
    rd_evt = bus_s3_r.ior_n && !bus_s2_r.ior_n;
    rd_port_addr = {6'h00, rdport_r, 2'h3};
    rdport_hit = en_r && (bus_s2_r.addr == rd_port_addr);
    chk_hit = check_r[`CHECK_EN_BIT] && !active_r && !rdport_hit
              && in_window(bus_s2_r.addr, base_of(cfg_r));
  end

  // Next-state computation for the whole register bank
  always_comb begin
    index_nxt = index_r;
    rdport_nxt = rdport_r;
    active_nxt = active_r;
    check_nxt = check_r;
    cfg_nxt = cfg_r;
    auto_nxt = auto_r;
    auto_req_nxt = 1'b0;
    pull_nxt = pull_r;
    levels_nxt = levels_r;
    en_nxt = en_r;
    mode_nxt = mode_r;
    src_auto_nxt = src_auto_r;
    std_pos_nxt = std_pos_r;
    ven_pos_nxt = ven_pos_r;
    dout_nxt = dout_r;
    doe_n_nxt = doe_n_r;
    // MCU loads defaults read from EEPROM; a host write below wins
    if (mcu_auto_wr) begin
      auto_nxt = mcu_auto_data;
    end
    if (wr_evt && bus_s2_r.addr == `ADDR_PORT) begin
      // Address port carries key bytes and, once open, the index
      std_pos_nxt = key_step(bus_s2_r.data, STD_KEY[std_pos_r], STD_KEY[0], std_pos_r);
      ven_pos_nxt = key_step(bus_s2_r.data, VEN_KEY[ven_pos_r], VEN_KEY[0], ven_pos_r);
      if (std_pos_r == `KEY_LAST && bus_s2_r.data == STD_KEY[`KEY_LAST]) begin
        en_nxt = 1'b1;
        mode_nxt = MODE_STANDARD;
        std_pos_nxt = 5'h00;
      end
      if (ven_pos_r == `KEY_LAST && bus_s2_r.data == VEN_KEY[`KEY_LAST]) begin
        en_nxt = 1'b1;
        mode_nxt = MODE_VENDOR;
        ven_pos_nxt = 5'h00;
      end
      if (en_r) begin
        index_nxt = bus_s2_r.data;
      end
    end
    if (wr_evt && en_r && bus_s2_r.addr == `WDATA_PORT) begin
      // Data port write to the selected register
      case (index_r)
        `IDX_RDPORT: rdport_nxt = bus_s2_r.data;
        `IDX_ACTIVATE: active_nxt = bus_s2_r.data[`ACTIVATE_BIT];
        `IDX_CHECK: check_nxt = bus_s2_r.data[1:0];
        `IDX_BASE_HI: begin
          cfg_nxt.base_hi = bus_s2_r.data;
          src_auto_nxt = 1'b0;
        end
        `IDX_BASE_LO: begin
          cfg_nxt.base_lo = bus_s2_r.data[7:3];
          src_auto_nxt = 1'b0;
        end
        `IDX_IRQ_SEL: begin
          cfg_nxt.irq_sel = bus_s2_r.data[3:0];
          src_auto_nxt = 1'b0;
        end
        `IDX_AUTO: begin
          auto_nxt = bus_s2_r.data;
          auto_req_nxt = 1'b1;
          src_auto_nxt = 1'b1;
        end
        `IDX_SAMPLE: begin
          if (bus_s2_r.data[`SAMPLE_BIT]) begin
            levels_nxt = {irq_s2_r[15], irq_s2_r[12], irq_s2_r[11], irq_s2_r[10],
                          irq_s2_r[7], irq_s2_r[5], irq_s2_r[4], irq_s2_r[3]};
          end
          pull_nxt = bus_s2_r.data[`PULL_BIT];
        end
        default: begin
          // Read-only and undefined indexes keep every value
        end
      endcase
    end
    // Read answer: held until the host lifts its read strobe
    if (rd_evt && rdport_hit) begin
      dout_nxt = read_mux(index_r);
      doe_n_nxt = 1'b0;
    end else if (rd_evt && chk_hit) begin
      dout_nxt = check_r[`CHECK_PAT_BIT] ? `CHECK_ANS_ONE : `CHECK_ANS_ZERO;
      doe_n_nxt = 1'b0;
    end else if (bus_s2_r.ior_n) begin
      doe_n_nxt = 1'b1;
    end
    // Flag follows the selection that the register stage is about to take
    irq_ok_nxt = (cfg_nxt.irq_sel != 4'h0);
  end

  // Register stage; reset reverts base and IRQ selection to stored defaults, other host settings to constants
  always_ff @(posedge core_clk) begin
    if (srst) begin
      index_r <= `INDEX_RST;
      rdport_r <= `RDPORT_RST;
      active_r <= 1'b0;
      check_r <= 2'h0;
      cfg_r <= dflt_cfg;
      auto_r <= `AUTO_RST;
      auto_req_r <= 1'b0;
      pull_r <= 1'b0;
      levels_r <= 8'h00;
      en_r <= 1'b0;
      mode_r <= MODE_VENDOR;
      src_auto_r <= 1'b1;
      std_pos_r <= 5'h00;
      ven_pos_r <= 5'h00;
      dout_r <= 8'h00;
      doe_n_r <= 1'b1;
    end else begin
      index_r <= index_nxt;
      rdport_r <= rdport_nxt;
      active_r <= active_nxt;
      check_r <= check_nxt;
      cfg_r <= cfg_nxt;
      auto_r <= auto_nxt;
      auto_req_r <= auto_req_nxt;
      pull_r <= pull_nxt;
      levels_r <= levels_nxt;
      en_r <= en_nxt;
      mode_r <= mode_nxt;
      src_auto_r <= src_auto_nxt;
      std_pos_r <= std_pos_nxt;
      ven_pos_r <= ven_pos_nxt;
      dout_r <= dout_nxt;
      doe_n_r <= doe_n_nxt;
    end
  end

  // Valid-selection flag kept as its own flop so the port is registered
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_ok_r <= 1'b0;
    end else begin
      irq_ok_r <= irq_ok_nxt;
    end
  end

  // Ports straight from flops
  assign isa_dout = dout_r;
  assign isa_doe_n = doe_n_r;
  assign dev_active = active_r;
  assign dev_cfg = cfg_r;
  assign irq_sel_valid = irq_ok_r;
  assign pull_low_en = pull_r;
  assign auto_setup = auto_r;
  assign auto_req = auto_req_r;
  assign cfg_enabled = en_r;
  assign cfg_mode = mode_r;
  assign cfg_from_auto = src_auto_r;

  // Logical device number always answers zero
  AST_LDN_ZERO: assert property (@(posedge core_clk) disable iff (srst)
    (rd_evt && rdport_hit && index_r == `IDX_LDN) |=> (!isa_doe_n && isa_dout == 8'h00))
    else $error("logical device number not zero");

  // Activate write shows on the active output next cycle
  AST_ACTIVATE: assert property (@(posedge core_clk) disable iff (srst)
    (wr_evt && en_r && bus_s2_r.addr == `WDATA_PORT && index_r == `IDX_ACTIVATE)
    |=> (dev_active == $past(bus_s2_r.data[0])))
    else $error("activate bit not applied");

  // No range-check answer while the device is active
  AST_CHECK_INACTIVE: assert property (@(posedge core_clk) disable iff (srst)
    (rd_evt && !rdport_hit && active_r && isa_doe_n) |=> isa_doe_n)
    else $error("range check answered while active");

  // Range-check answer pattern follows bit zero
  AST_CHECK_PATTERN: assert property (@(posedge core_clk) disable iff (srst)
    (rd_evt && chk_hit) |=> (!isa_doe_n
      && isa_dout == ($past(check_r[0]) ? 8'h55 : 8'haa)))
    else $error("range check pattern wrong");

  // IRQ type reads as 02
  AST_IRQ_TYPE: assert property (@(posedge core_clk) disable iff (srst)
    (rd_evt && rdport_hit && index_r == `IDX_IRQ_TYPE) |=> (isa_dout == 8'h02))
    else $error("irq type value wrong");

  // Sample write latches the mapped line levels
  AST_SAMPLE: assert property (@(posedge core_clk) disable iff (srst)
    (wr_evt && en_r && bus_s2_r.addr == `WDATA_PORT && index_r == `IDX_SAMPLE
     && bus_s2_r.data[0]) |=> (levels_r[3] == $past(irq_s2_r[7])
     && levels_r[7] == $past(irq_s2_r[15]) && levels_r[0] == $past(irq_s2_r[3])))
    else $error("irq levels not latched");

  // Ports open only right after an address-port write
  AST_KEY_OPEN: assert property (@(posedge core_clk) disable iff (srst)
    $rose(en_r) |-> $past(wr_evt && bus_s2_r.addr == `ADDR_PORT))
    else $error("ports opened without key");

  // Completing the standard key selects standard mode
  AST_STD_MODE: assert property (@(posedge core_clk) disable iff (srst)
    (wr_evt && bus_s2_r.addr == `ADDR_PORT && std_pos_r == 5'h1f && bus_s2_r.data == 8'h39)
    |=> (cfg_enabled && cfg_mode == MODE_STANDARD))
    else $error("standard key not honoured");

  // Read-only indexes keep every stored value
  AST_RO_WRITE: assert property (@(posedge core_clk) disable iff (srst)
    (wr_evt && bus_s2_r.addr == `WDATA_PORT && (index_r == `IDX_IRQ_TYPE
     || index_r == `IDX_LEVELS || index_r == `IDX_LDN) && !mcu_auto_wr)
    |=> ($stable(cfg_r) && $stable(auto_r) && $stable(levels_r) && $stable(active_r)))
    else $error("read-only write changed state");

  // Reset restores the stored defaults
  AST_RESET_DEFAULT: assert property (@(posedge core_clk)
    srst |=> (dev_cfg == $past(dflt_cfg) && cfg_mode == MODE_VENDOR && !cfg_enabled))
    else $error("defaults not restored at reset");

  // Completing the vendor key selects vendor mode
  AST_VEN_MODE: assert property (@(posedge core_clk) disable iff (srst)
    (wr_evt && bus_s2_r.addr == `ADDR_PORT && ven_pos_r == 5'h1f && bus_s2_r.data == 8'h5d)
    |=> (cfg_enabled && cfg_mode == MODE_VENDOR))
    else $error("vendor key not honoured");

  // A wrong byte that is not a new first byte sends the detector back to zero
  AST_KEY_RESTART: assert property (@(posedge core_clk) disable iff (srst)
    (wr_evt && bus_s2_r.addr == `ADDR_PORT && bus_s2_r.data != STD_KEY[std_pos_r]
     && bus_s2_r.data != STD_KEY[0]) |=> (std_pos_r == 5'h00))
    else $error("key detector not restarted");

  // Undefined and write-only indexes read back as zero
  AST_UNDEF_ZERO: assert property (@(posedge core_clk) disable iff (srst)
    (rd_evt && rdport_hit && !(index_r inside {8'h07, 8'h30, 8'h31, 8'h60, 8'h61, 8'h70,
     8'h71, 8'hf0, 8'hf2})) |=> (!isa_doe_n && isa_dout == 8'h00))
    else $error("undefined index not zero");

  // Data-port writes before the key leave every setting alone
  AST_PORTS_CLOSED: assert property (@(posedge core_clk) disable iff (srst)
    (wr_evt && !en_r && bus_s2_r.addr == `WDATA_PORT && !mcu_auto_wr)
    |=> ($stable(dev_cfg) && $stable(auto_setup) && $stable(dev_active) && !auto_req))
    else $error("closed data port accepted a write");

  // Host auto setup write stores the byte, raises the request, selects auto source
  AST_AUTO_REQ: assert property (@(posedge core_clk) disable iff (srst)
    (wr_evt && en_r && bus_s2_r.addr == `WDATA_PORT && index_r == `IDX_AUTO)
    |=> (auto_req && cfg_from_auto && auto_setup == $past(bus_s2_r.data)))
    else $error("auto setup write not taken");

  // Controller load lands unless a host auto setup write falls in the same cycle
  AST_MCU_LOAD: assert property (@(posedge core_clk) disable iff (srst)
    (mcu_auto_wr && !(wr_evt && en_r && bus_s2_r.addr == `WDATA_PORT && index_r == `IDX_AUTO))
    |=> (auto_setup == $past(mcu_auto_data)))
    else $error("controller auto setup load lost");

endmodule : isa_pnp_config_logic
`default_nettype wire

/* File: verification/isa_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side of the ISA bus: one I/O cycle at a time, strobes held for fixed spans
module isa_host_model (
  input wire logic core_clk, // System clock
  input wire logic [7:0] isa_dout, // Card answer data
  input wire logic isa_doe_n, // Card drive enable, low drives
  output logic [15:0] isa_addr, // Host address pins
  output logic [7:0] isa_din, // Data bus level seen by the card
  output logic isa_ior_n, // Read strobe
  output logic isa_iow_n // Write strobe
);
  logic [7:0] host_d; // Byte put on the bus by the host
  logic host_drv; // Host drives the data bus
  logic [7:0] last_q; // Last bus level
  initial begin
    isa_addr = 16'h0000;
    host_d = 8'h00;
    host_drv = 1'b0;
    last_q = 8'h00;
    isa_ior_n = 1'b1;
    isa_iow_n = 1'b1;
  end
  // A released bus toggles every cycle, so stale data never reads as an answer
  assign isa_din = host_drv ? host_d : (!isa_doe_n ? isa_dout : ~last_q);
  always @(posedge core_clk) begin
    last_q <= isa_din;
  end
  // Plain bus cycles only, address stable before and during the strobe
  task automatic cycle(input logic [15:0] a, input logic [7:0] d, input logic rd,
                       output logic [7:0] q, output logic drv);
    @(posedge core_clk);
    isa_addr <= a;
    host_d <= d;
    host_drv <= !rd;
    repeat (3) @(posedge core_clk);
    isa_ior_n <= !rd;
    isa_iow_n <= rd;
    // Low six cycles: answer lands three cycles after the pin falls
    repeat (6) @(posedge core_clk);
    q = isa_din;
    drv = !isa_doe_n;
    isa_ior_n <= 1'b1;
    isa_iow_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    host_drv <= 1'b0;
  endtask : cycle
endmodule : isa_host_model
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import isa_pnp_pkg::*;
  logic core_clk, srst, mcu_auto_wr; // Clock, reset, MCU strobe
  logic [15:0] irq_pins; // Interrupt line levels
  logic [7:0] mcu_auto_data; // MCU auto setup value
  dev_cfg_s dflt_cfg, dev_cfg; // Stored defaults and live config
  wire logic [15:0] isa_addr;
  wire logic [7:0] isa_din;
  wire logic isa_ior_n, isa_iow_n;
  logic [7:0] isa_dout, auto_setup, q_s;
  logic isa_doe_n, dev_active, irq_sel_valid, pull_low_en, auto_req, cfg_enabled;
  logic cfg_from_auto, drv_s;
  cfg_mode_e cfg_mode;
  int fails, n_tests, n_req;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [7:0] expv;
  } row_s;
  // Index, written byte, expected read-back
  localparam row_s ROWS [0:8] = '{
    '{8'h07, 8'hff, 8'h00}, '{8'h30, 8'h00, 8'h00}, '{8'h60, 8'h03, 8'h03},
    '{8'h61, 8'hff, 8'hf8}, '{8'h70, 8'h00, 8'h00}, '{8'h70, 8'h0b, 8'h0b},
    '{8'h71, 8'hff, 8'h02}, '{8'hf0, 8'h5a, 8'h5a}, '{8'h22, 8'h77, 8'h00}};
  isa_pnp_config_logic u_dut (.core_clk(core_clk), .srst(srst), .isa_addr(isa_addr),
    .isa_din(isa_din), .isa_ior_n(isa_ior_n), .isa_iow_n(isa_iow_n), .irq_pins(irq_pins),
    .dflt_cfg(dflt_cfg), .mcu_auto_wr(mcu_auto_wr), .mcu_auto_data(mcu_auto_data),
    .isa_dout(isa_dout), .isa_doe_n(isa_doe_n), .dev_active(dev_active), .dev_cfg(dev_cfg),
    .irq_sel_valid(irq_sel_valid), .pull_low_en(pull_low_en), .auto_setup(auto_setup),
    .auto_req(auto_req), .cfg_enabled(cfg_enabled), .cfg_mode(cfg_mode),
    .cfg_from_auto(cfg_from_auto));
  isa_host_model u_host (.core_clk(core_clk), .isa_dout(isa_dout), .isa_doe_n(isa_doe_n),
    .isa_addr(isa_addr), .isa_din(isa_din), .isa_ior_n(isa_ior_n), .isa_iow_n(isa_iow_n));
  always #2 core_clk = ~core_clk;
  // Counts host-side update requests towards the MCU
  always @(posedge core_clk) begin
    if (auto_req === 1'b1) begin
      n_req <= n_req + 1;
    end
  end
  task automatic chk(input logic [16:0] got, input logic [16:0] expv, input string what);
    n_tests++;
    if (got !== expv) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, expv);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_host.cycle(a, d, 1'b0, q_s, drv_s);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    u_host.cycle(a, 8'h00, 1'b1, q_s, drv_s);
  endtask : rd
  task automatic setr(input logic [7:0] idx, input logic [7:0] d);
    wr(16'h0279, idx);
    wr(16'h0a79, d);
  endtask : setr
  // Read a register through the default read port
  task automatic getr(input logic [7:0] idx);
    wr(16'h0279, idx);
    rd(16'h0203);
  endtask : getr
  // Sends a whole key; a stray zero byte goes in before byte number bad
  task automatic send_key(input logic vendor, input int bad);
    for (int i = 0; i < 32; i++) begin
      if (i == bad) begin
        wr(16'h0279, 8'h00);
      end
      wr(16'h0279, vendor ? VEN_KEY[i] : STD_KEY[i]);
    end
  endtask : send_key
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  // Watchdog so that a hang still ends in the report
  initial begin
    repeat (60000) @(posedge core_clk);
    fails++;
    summarize();
  end
  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    irq_pins = 16'h0000;
    mcu_auto_wr = 1'b0;
    mcu_auto_data = 8'h00;
    dflt_cfg = '{8'h02, 5'h1f, 4'h5};
    {fails, n_tests, n_req} = '0;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(dev_cfg, dflt_cfg, "reset config");
    chk(cfg_mode, MODE_VENDOR, "reset mode");
    chk({cfg_enabled, dev_active, cfg_from_auto}, 3'b001, "reset flags");
    chk({STD_KEY[0], STD_KEY[31]}, 16'h6a39, "std key ends");
    chk({VEN_KEY[0], VEN_KEY[31]}, 16'h685d, "vendor key ends");
    // Data port writes before any key are refused
    setr(8'h60, 8'h55);
    send_key(1'b0, 10);
    chk(cfg_enabled, 1'b0, "broken key");
    send_key(1'b0, 32);
    chk({cfg_enabled, cfg_mode}, {1'b1, MODE_STANDARD}, "std key");
    getr(8'h60);
    chk(q_s, dflt_cfg.base_hi, "refused write");
    foreach (ROWS[i]) begin
      setr(ROWS[i].idx, ROWS[i].wdata);
      getr(ROWS[i].idx);
      chk(q_s, ROWS[i].expv, "row read");
    end
    chk(n_req, 1, "update request");
    chk({irq_sel_valid, cfg_from_auto}, 2'b11, "irq select");
    setr(8'h70, 8'h00);
    chk({irq_sel_valid, cfg_from_auto}, 2'b00, "irq zero");
    // Range window at 0300 while inactive
    setr(8'h61, 8'h00);
    setr(8'h31, 8'h02);
    rd(16'h0305);
    chk(q_s, 8'haa, "range aa");
    setr(8'h31, 8'h03);
    rd(16'h0307);
    chk(q_s, 8'h55, "range 55");
    // Check cleared before activation, then enabled again while active
    setr(8'h31, 8'h00);
    setr(8'h30, 8'h01);
    chk(dev_active, 1'b1, "activate");
    setr(8'h31, 8'h02);
    rd(16'h0305);
    chk(drv_s, 1'b0, "range while active");
    setr(8'h30, 8'h00);
    chk(dev_active, 1'b0, "deactivate");
    // Levels latched on the sample write, later pin changes unseen
    irq_pins <= 16'h8090;
    setr(8'hf1, 8'h03);
    irq_pins <= 16'h7f6f;
    getr(8'hf2);
    chk(q_s, 8'h8a, "irq levels");
    chk(pull_low_en, 1'b1, "pull low");
    @(posedge core_clk);
    mcu_auto_wr <= 1'b1;
    mcu_auto_data <= 8'h3c;
    @(posedge core_clk);
    mcu_auto_wr <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({auto_setup, n_req[7:0]}, 16'h3c01, "mcu write");
    send_key(1'b1, 32);
    chk(cfg_mode, MODE_VENDOR, "vendor key");
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(dev_cfg, dflt_cfg, "revert");
    chk({cfg_enabled, cfg_from_auto}, 2'b01, "revert flags");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
